// *** verilog/dasc_defines.svh ***
/*
  Offsets, field positions, reset values and timing figures of the dual
  asynchronous serial channel block.
  Assumes inclusion by the top level and by the bench files.
*/
`ifndef DASC_DEFINES_SVH
`define DASC_DEFINES_SVH

// ==========================================================
// clock and bit rates
`define DASC_CLK_HZ 25000000
`define DASC_BPS_0 300
`define DASC_BPS_1 600
`define DASC_BPS_2 1200
`define DASC_BPS_3 2400
`define DASC_BPS_4 4800
`define DASC_BPS_5 9600
`define DASC_BPS_6 19200

// ==========================================================
// channel indices and flow control characters
`define DASC_CH_HOST 0
`define DASC_CH_PROG 1
`define DASC_XON 7'h11
`define DASC_XOFF 7'h13

// ==========================================================
// register byte offsets
`define DASC_CTRL 12'h000
`define DASC_STATUS 12'h004
`define DASC_HOST_DATA 12'h008
`define DASC_PROG_DATA 12'h00c

// ==========================================================
// control fields and reset (9600 bps, ready line, 8 bits, none, 2 stops)
`define DASC_C_RATE 0
`define DASC_C_HS_SW 3
`define DASC_C_LEN8 4
`define DASC_C_PAR 5
`define DASC_C_STOP2 7
`define DASC_CTRL_RST 32'h0000_0095

// ==========================================================
// status fields, one byte per channel
`define DASC_S_TXE 0
`define DASC_S_RXV 1
`define DASC_S_PERR 2
`define DASC_S_FERR 3
`define DASC_S_OVR 4
`define DASC_S_PAUSE 5
`define DASC_S_CTS 6
`define DASC_S_MODEM 7
`define DASC_S_RATE 16

`endif

// *** verilog/dasc_pkg.sv ***
/*
  Types shared by the serial channel block.
  Assumes dasc_defines.svh is on the include path.
*/
package dasc_pkg;
  typedef enum logic [1:0] {
    DASC_PAR_NONE = 2'b00,
    DASC_PAR_EVEN = 2'b01,
    DASC_PAR_ODD = 2'b10
  } dasc_par_t;

  typedef struct packed {
    logic len8;
    dasc_par_t par;
    logic stop2;
  } dasc_fmt_t;

  typedef struct packed {
    logic [7:0] data;
    logic perr;
    logic ferr;
  } dasc_rx_t;

  typedef enum logic {DASC_TX_IDLE = 1'b0, DASC_TX_SHIFT = 1'b1} dasc_tx_st_t;
  typedef enum logic {DASC_RX_IDLE = 1'b0, DASC_RX_RUN = 1'b1} dasc_rx_st_t;
endpackage : dasc_pkg

// *** verilog/dasc_chan.sv ***
/*
  One asynchronous serial engine: a transmitter and a receiver.
  Assumes rxd is already synchronised and tx_start comes only while
  tx_idle is high.
*/
`timescale 1ns/1ps
module dasc_chan
  import dasc_pkg::*;
#(
  parameter int DIV_W = 17
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] bit_cyc,
  input wire dasc_fmt_t fmt,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_idle,
  output logic txd,
  input wire logic rxd,
  output logic rx_stb,
  output dasc_rx_t rx_word
);
  // ==========================================================
  // frame shape
  logic [3:0] nd;
  logic [3:0] nbits;
  logic has_par;
  assign nd = fmt.len8 ? 4'd8 : 4'd7;
  assign has_par = (fmt.par != DASC_PAR_NONE);
  assign nbits = nd + {3'b000, has_par} + (fmt.stop2 ? 4'd3 : 4'd2);

  function automatic logic par_of(input logic [7:0] d, input dasc_fmt_t f);
    logic p;
    p = f.len8 ? ^d : ^d[6:0];
    return (f.par == DASC_PAR_ODD) ? ~p : p;
  endfunction : par_of

  // ==========================================================
  // transmitter
  dasc_tx_st_t tx_st_q;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [DIV_W-1:0] tx_cnt_q;
  logic [11:0] frame;

  always_comb begin
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nd)) frame[i+1] = tx_data[i];
    end
    if (has_par) frame[nd+4'd1] = par_of(tx_data, fmt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= DASC_TX_IDLE;
      tx_sh_q <= '1;
      tx_left_q <= 4'h0;
      tx_cnt_q <= '0;
    end else begin
      case (tx_st_q)
        DASC_TX_IDLE: begin
          if (tx_start) begin
            tx_sh_q <= frame;
            tx_left_q <= nbits;
            tx_cnt_q <= bit_cyc - 1'b1;
            tx_st_q <= DASC_TX_SHIFT;
          end
        end
        DASC_TX_SHIFT: begin
          if (tx_cnt_q == '0) begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_left_q <= tx_left_q - 4'd1;
            tx_cnt_q <= bit_cyc - 1'b1;
            if (tx_left_q == 4'd1) tx_st_q <= DASC_TX_IDLE;
          end else begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
          end
        end
        default: tx_st_q <= DASC_TX_IDLE;
      endcase
    end
  end
  assign tx_idle = (tx_st_q == DASC_TX_IDLE);
  assign txd = tx_sh_q[0];

  // ==========================================================
  // receiver: samples mid-bit after a falling edge
  dasc_rx_st_t rx_st_q;
  logic rxd_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q;
  logic rx_ferr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= DASC_RX_IDLE;
      rxd_q <= 1'b1;
      rx_cnt_q <= '0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_stb <= 1'b0;
      rx_word <= '0;
    end else begin
      rxd_q <= rxd;
      rx_stb <= 1'b0;
      case (rx_st_q)
        DASC_RX_IDLE: begin
          if (rxd_q && !rxd) begin
            rx_cnt_q <= bit_cyc >> 1;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_ferr_q <= 1'b0;
            rx_st_q <= DASC_RX_RUN;
          end
        end
        DASC_RX_RUN: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else begin
            rx_cnt_q <= bit_cyc - 1'b1;
            rx_idx_q <= rx_idx_q + 4'd1;
            if (rx_idx_q == 4'h0) begin
              // a glitch, not a start bit
              if (rxd) rx_st_q <= DASC_RX_IDLE;
            end else if (rx_idx_q <= nd) begin
              rx_sh_q[3'(rx_idx_q - 4'd1)] <= rxd;
            end else if (has_par && rx_idx_q == nd + 4'd1) begin
              rx_par_q <= rxd;
            end else if (!rxd) begin
              rx_ferr_q <= 1'b1;
            end
            if (rx_idx_q == nbits - 4'd1 && rx_idx_q != 4'h0) begin
              rx_st_q <= DASC_RX_IDLE;
              rx_stb <= 1'b1;
              rx_word.data <= rx_sh_q;
              rx_word.ferr <= rx_ferr_q | ~rxd;
              rx_word.perr <= has_par & (rx_par_q != par_of(rx_sh_q, fmt));
            end
          end
        end
        default: rx_st_q <= DASC_RX_IDLE;
      endcase
    end
  end
endmodule : dasc_chan

// *** verilog/dasc_top.sv ***
/*
  Two asynchronous serial channels behind an APB register slave:
  index 0 is the host_serial_channel, index 1 the
  programmer_serial_channel.
  Assumes an APB3 master on pclk; pins and switches are asynchronous
  and pass two flip-flops here.
*/
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "dasc_defines.svh"
module dasc_top
  import dasc_pkg::*;
#(
  parameter int CLK_HZ = `DASC_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] host_rate_sel,
  input wire logic [1:0] ser_role_modem,
  input wire logic [1:0] ser_p2_i,
  output logic [1:0] ser_p2_o,
  output logic [1:0] ser_p2_oe,
  input wire logic [1:0] ser_p3_i,
  output logic [1:0] ser_p3_o,
  output logic [1:0] ser_p3_oe,
  output logic [1:0] ser_rts_o,
  input wire logic [1:0] ser_cts_i
);
  localparam int DIV_W = 17;
  localparam dasc_fmt_t HOST_FMT = '{len8: 1'b1, par: DASC_PAR_NONE,
                                     stop2: 1'b1};

  // ==========================================================
  // helpers
  function automatic logic [DIV_W-1:0] rate_div(input logic [2:0] idx);
    int r;
    case (idx)
      3'h0: r = `DASC_BPS_0;
      3'h1: r = `DASC_BPS_1;
      3'h2: r = `DASC_BPS_2;
      3'h3: r = `DASC_BPS_3;
      3'h4: r = `DASC_BPS_4;
      3'h5: r = `DASC_BPS_5;
      default: r = `DASC_BPS_6;
    endcase
    // nearest whole cycle keeps the rate error under half a clock
    return DIV_W'((CLK_HZ + r / 2) / r);
  endfunction : rate_div

  function automatic logic [11:0] data_addr(input int ch);
    return (ch == `DASC_CH_HOST) ? `DASC_HOST_DATA : `DASC_PROG_DATA;
  endfunction : data_addr

  function automatic logic mapped(input logic [11:0] a);
    return a == `DASC_CTRL || a == `DASC_STATUS ||
           a == `DASC_HOST_DATA || a == `DASC_PROG_DATA;
  endfunction : mapped

  // ==========================================================
  // apb slave: one wait state, so every output leaves a flip-flop
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] ctrl_q;
  logic [31:0] rd_val;
  logic acc;
  logic wr;
  logic rd_cap;
  logic [15:0] stat_w;
  logic [15:0] rxd_w;
  logic [2:0] host_rate_q0;
  logic [2:0] host_rate_q1;

  assign acc = psel & penable;
  assign wr = acc & pready_q & pwrite;
  // reads pop at the edge that captures prdata so no late arrival is lost
  assign rd_cap = acc & ~pready_q & ~pwrite;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `DASC_CTRL: rd_val = ctrl_q;
      `DASC_STATUS: rd_val = {13'h0000, host_rate_q1, stat_w};
      `DASC_HOST_DATA: rd_val = {24'h00_0000, rxd_w[7:0]};
      `DASC_PROG_DATA: rd_val = {24'h00_0000, rxd_w[15:8]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (acc && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped(paddr);
      prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DASC_CTRL_RST;
    end else if (wr && paddr == `DASC_CTRL) begin
      ctrl_q <= {24'h00_0000, pwdata[7:0]};
    end
  end

  // ==========================================================
  // host rate switch, synchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rate_q0 <= 3'h0;
      host_rate_q1 <= 3'h0;
    end else begin
      host_rate_q0 <= host_rate_sel;
      host_rate_q1 <= host_rate_q0;
    end
  end

  // ==========================================================
  // channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [1:0] p2_s;
    logic [1:0] p3_s;
    logic [1:0] cts_s;
    logic [1:0] role_s;
    logic role;
    logic rxd;
    logic cts;
    dasc_fmt_t fmt;
    logic hw_en;
    logic sw_en;
    logic [DIV_W-1:0] div;
    logic txh_valid_q;
    logic [7:0] txh_data_q;
    logic rxh_valid_q;
    logic [7:0] rxh_data_q;
    logic perr_q;
    logic ferr_q;
    logic ovr_q;
    logic paused_q;
    logic stopped_q;
    logic p2_o_q;
    logic p2_oe_q;
    logic p3_o_q;
    logic p3_oe_q;
    logic rts_q;
    logic tx_idle;
    logic txd;
    logic rx_stb;
    dasc_rx_t rx_word;
    logic flow_need;
    logic send_data;
    logic tx_start;
    logic [7:0] tx_byte;
    logic pop;
    logic is_flow;
    logic [7:0] clr;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        p2_s <= 2'b11;
        p3_s <= 2'b11;
        cts_s <= 2'b00;
        role_s <= 2'b00;
      end else begin
        p2_s <= {p2_s[0], ser_p2_i[i]};
        p3_s <= {p3_s[0], ser_p3_i[i]};
        cts_s <= {cts_s[0], ser_cts_i[i]};
        role_s <= {role_s[0], ser_role_modem[i]};
      end
    end
    assign role = role_s[1];
    assign cts = cts_s[1];
    // modem role listens on pin 2, terminal role on pin 3
    assign rxd = role ? p2_s[1] : p3_s[1];

    assign fmt = (i == `DASC_CH_HOST) ? HOST_FMT :
      dasc_fmt_t'({ctrl_q[`DASC_C_LEN8], ctrl_q[`DASC_C_PAR +: 2],
                   ctrl_q[`DASC_C_STOP2]});
    assign hw_en = (i == `DASC_CH_HOST) | ~ctrl_q[`DASC_C_HS_SW];
    assign sw_en = (i == `DASC_CH_HOST) | ctrl_q[`DASC_C_HS_SW];
    assign div = rate_div((i == `DASC_CH_HOST) ? host_rate_q1 :
                          ctrl_q[`DASC_C_RATE +: 3]);

    // flow chars go first and ignore pauses so xoff is never held back
    assign flow_need = sw_en & (rxh_valid_q != stopped_q);
    assign send_data = txh_valid_q & ~(sw_en & paused_q) &
                       ~(hw_en & ~cts);
    assign tx_start = tx_idle & (flow_need | send_data);
    assign tx_byte = flow_need ?
      {1'b0, rxh_valid_q ? `DASC_XOFF : `DASC_XON} : txh_data_q;
    assign pop = rd_cap & (paddr == data_addr(i));
    assign is_flow = sw_en & (rx_word.data[6:0] == `DASC_XON ||
                              rx_word.data[6:0] == `DASC_XOFF);
    assign clr = (wr && paddr == `DASC_STATUS) ? pwdata[i*8 +: 8] : 8'h00;

    dasc_chan #(.DIV_W(DIV_W)) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .bit_cyc(div),
      .fmt(fmt),
      .tx_start(tx_start),
      .tx_data(tx_byte),
      .tx_idle(tx_idle),
      .txd(txd),
      .rxd(rxd),
      .rx_stb(rx_stb),
      .rx_word(rx_word)
    );

    // transmit holding byte: a write while full is dropped
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        txh_valid_q <= 1'b0;
        txh_data_q <= 8'h00;
      end else if (wr && paddr == data_addr(i) && !txh_valid_q) begin
        txh_valid_q <= 1'b1;
        txh_data_q <= {1'b0, pwdata[6:0]};
      end else if (tx_start && !flow_need) begin
        txh_valid_q <= 1'b0;
      end
    end

    // one-character receive holding; a new char beats a same-cycle pop
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rxh_valid_q <= 1'b0;
        rxh_data_q <= 8'h00;
      end else if (rx_stb && !is_flow) begin
        rxh_valid_q <= 1'b1;
        rxh_data_q <= {1'b0, rx_word.data[6:0]};
      end else if (pop) begin
        rxh_valid_q <= 1'b0;
      end
    end

    // sticky errors, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        perr_q <= 1'b0;
        ferr_q <= 1'b0;
        ovr_q <= 1'b0;
      end else begin
        perr_q <= (rx_stb & rx_word.perr) | (perr_q & ~clr[`DASC_S_PERR]);
        ferr_q <= (rx_stb & rx_word.ferr) | (ferr_q & ~clr[`DASC_S_FERR]);
        ovr_q <= (rx_stb & ~is_flow & rxh_valid_q & ~pop) |
                 (ovr_q & ~clr[`DASC_S_OVR]);
      end
    end

    // software flow control state, both directions
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        paused_q <= 1'b0;
        stopped_q <= 1'b0;
      end else if (!sw_en) begin
        paused_q <= 1'b0;
        stopped_q <= 1'b0;
      end else begin
        if (rx_stb && is_flow) begin
          paused_q <= (rx_word.data[6:0] == `DASC_XOFF);
        end
        if (tx_start && flow_need) stopped_q <= rxh_valid_q;
      end
    end

    // pins: role swaps the data pins, ready line drops while full
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        p2_o_q <= 1'b1;
        p2_oe_q <= 1'b0;
        p3_o_q <= 1'b1;
        p3_oe_q <= 1'b0;
        rts_q <= 1'b0;
      end else begin
        p2_o_q <= role ? 1'b1 : txd;
        p2_oe_q <= ~role;
        p3_o_q <= role ? txd : 1'b1;
        p3_oe_q <= role;
        rts_q <= hw_en ? ~rxh_valid_q : 1'b1;
      end
    end

    assign ser_p2_o[i] = p2_o_q;
    assign ser_p2_oe[i] = p2_oe_q;
    assign ser_p3_o[i] = p3_o_q;
    assign ser_p3_oe[i] = p3_oe_q;
    assign ser_rts_o[i] = rts_q;
    assign stat_w[i*8 +: 8] = {role, cts, paused_q, ovr_q, ferr_q, perr_q,
                               rxh_valid_q, ~txh_valid_q};
    assign rxd_w[i*8 +: 8] = rxh_data_q;
  end
endmodule : dasc_top

// *** dv/dasc_top_props.sv ***
/*
  Port checker for dasc_top: register bus timing, pin roles, bit length.
  Assumes binding into dasc_top with a single clock pclk and reset presetn.
*/
`timescale 1ns/1ps
`include "dasc_defines.svh"
module dasc_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] ser_p2_o,
  input wire logic [1:0] ser_p2_oe,
  input wire logic [1:0] ser_p3_o,
  input wire logic [1:0] ser_p3_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // register bus
  a_ready_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_single: assert property (
    pready |=> !pready) else $error("pready too long");
  a_ready_in_access: assert property (
    pready |-> psel && penable) else $error("pready outside access");
  a_err_unmapped: assert property (
    pready && paddr > `DASC_PROG_DATA |-> pslverr)
    else $error("unmapped access without error");
  a_no_err_mapped: assert property (
    pready && paddr <= `DASC_PROG_DATA && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged");
  a_err_zero_data: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("error read data");
  a_rx_top_zero: assert property (
    pready && !pwrite && paddr[11:3] == 9'h001 |-> prdata[31:7] == 25'h0)
    else $error("received top bit not cleared");
  // ==========================================================
  // serial pins
  a_pin_roles: assert property (
    $past(presetn) |-> (ser_p2_oe ^ ser_p3_oe) == 2'b11)
    else $error("pin roles clash");
  // even the fastest rate keeps a bit for 50 cycles in this bench
  a_bit_min_len: assert property (
    $changed(ser_p3_o[0]) |=> $stable(ser_p3_o[0])[*8])
    else $error("host bit too short");
endmodule : dasc_top_props
bind dasc_top dasc_top_props dasc_top_props_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ser_p2_o(ser_p2_o), .ser_p2_oe(ser_p2_oe),
  .ser_p3_o(ser_p3_o), .ser_p3_oe(ser_p3_oe));

// *** dv/dasc_far.sv ***
/*
  Far end of one serial link: host computer or programmer.
  Assumes the bench calls send and recv; par 0 none, 1 even, 2 odd.
*/
`timescale 1ns/1ps
module dasc_far (
  input wire logic pclk,
  input wire logic line_in,
  input wire logic rts,
  output logic line_out
);
  initial line_out = 1'b1;
  function automatic logic par_of(input logic [7:0] d, input int nb, par);
    return (nb == 7 ? ^d[6:0] : ^d) ^ (par == 2);
  endfunction : par_of
  task automatic send(input logic [7:0] d, input int nb, par, ns, bc);
    int n;
    n = 0;
    // a character only starts while the device says it may take one
    while (rts !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    // a device that never clears us to send ends the run as a failure
    if (rts !== 1'b1) begin
      dasc_top_tb_top.mismatches++;
      dasc_top_tb_top.final_report();
    end
    line_out <= 1'b0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (bc) @(posedge pclk);
    end
    if (par != 0) begin
      line_out <= par_of(d, nb, par);
      repeat (bc) @(posedge pclk);
    end
    line_out <= 1'b1;
    repeat (bc * ns) @(posedge pclk);
  endtask : send
  task automatic recv(output logic [7:0] d, output logic p, output logic ok,
                      input int nb, par, ns, bc, lim);
    int n;
    d = 8'h00;
    p = 1'b0;
    ok = 1'b0;
    n = 0;
    while (line_in !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n < lim) begin
      repeat (bc / 2) @(posedge pclk);
      ok = (line_in === 1'b0);
      for (int i = 0; i < nb; i++) begin
        repeat (bc) @(posedge pclk);
        d[i] = line_in;
      end
      if (par != 0) begin
        repeat (bc) @(posedge pclk);
        p = line_in;
      end
      for (int i = 0; i < ns; i++) begin
        repeat (bc) @(posedge pclk);
        if (line_in !== 1'b1) ok = 1'b0;
      end
    end
  endtask : recv
endmodule : dasc_far

// *** dv/dasc_top_tb_top.sv ***
/*
  Self-checking bench for dasc_top with a far end on each channel.
  Assumes CLK_HZ 960000, so 9600 bps is 100 cycles a bit.
*/
`timescale 1ns/1ps
`include "dasc_defines.svh"
module dasc_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, h_out, p_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] host_rate_sel;
  logic [1:0] role, p2_o, p2_oe, p3_o, p3_oe, rts, cts, p2_lvl, p3_lvl;
  int mismatches = 0;
  int comparisons = 0;
  int ctl_t[5] = '{32'h56, 32'ha5, 32'h05, 32'hb5, 32'h9d};
  int nb_t[5] = '{8, 7, 7, 8, 8};
  int par_t[5] = '{2, 1, 0, 1, 0};
  int ns_t[5] = '{1, 2, 1, 2, 2};
  int bc_t[5] = '{50, 100, 100, 100, 100};
  // undriven pins carry the far end's line on host pin 2 and prog pin 3, else the pull-up level
  assign p2_lvl = {p2_oe[1] ? p2_o[1] : 1'b1, p2_oe[0] ? p2_o[0] : h_out};
  assign p3_lvl = {p3_oe[1] ? p3_o[1] : p_out, p3_oe[0] ? p3_o[0] : 1'b1};
  dasc_top #(.CLK_HZ(960000)) dasc_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_rate_sel(host_rate_sel),
    .ser_role_modem(role), .ser_p2_i(p2_lvl), .ser_p2_o(p2_o),
    .ser_p2_oe(p2_oe), .ser_p3_i(p3_lvl), .ser_p3_o(p3_o),
    .ser_p3_oe(p3_oe), .ser_rts_o(rts), .ser_cts_i(cts));
  dasc_far h_far (.pclk(pclk), .line_in(p3_lvl[0]), .rts(rts[0]),
    .line_out(h_out));
  dasc_far p_far (.pclk(pclk), .line_in(p2_lvl[1]), .rts(rts[1]),
    .line_out(p_out));
  // ==========================================================
  // shared tasks
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = {prdata[31:1], prdata[0] | (pslverr === 1'b1 && a > 12'h00c)};
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rdm(input logic [11:0] a, input logic [31:0] mk, e,
                     input string m);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & mk, e, m);
  endtask : rdm
  task automatic hget(input logic [7:0] e, input int bc, input string m);
    logic [7:0] d;
    logic p, ok;
    h_far.recv(d, p, ok, 8, 0, 2, bc, bc * 30);
    chk({24'h0, d}, {24'h0, e}, m);
    chk({31'h0, ok}, 32'h1, m);
    if (ok !== 1'b1) final_report();
  endtask : hget
  task automatic pget(input logic [7:0] e, input int i, input string m);
    logic [7:0] d;
    logic p, ok;
    p_far.recv(d, p, ok, nb_t[i], par_t[i], ns_t[i], bc_t[i], 3000);
    chk({24'h0, d}, {24'h0, e}, m);
    chk({31'h0, ok}, 32'h1, m);
    if (ok !== 1'b1) final_report();
    if (par_t[i] != 0) begin
      chk({31'h0, p}, {31'h0, p_far.par_of(e, nb_t[i], par_t[i])}, m);
    end
  endtask : pget
  task automatic quiet(input string m);
    logic [7:0] d;
    logic p, ok;
    h_far.recv(d, p, ok, 8, 0, 2, 100, 600);
    chk({31'h0, ok}, 32'h0, m);
  endtask : quiet
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rdm(`DASC_CTRL, 32'hffff_ffff, `DASC_CTRL_RST, "ctrl reset");
    rdm(`DASC_STATUS, 32'h0007_8080, 32'h0005_0080, "status");
    rdm(12'h010, 32'hffff_ffff, 32'h1, "unmapped");
  endtask : t_regs
  task automatic t_host();
    wr(`DASC_HOST_DATA, 32'hc1);
    hget(8'h41, 100, "host tx");
    fork
      h_far.send(8'hc5, 8, 0, 2, 100);
      hget(8'h13, 100, "host xoff");
    join
    chk({31'h0, rts[0]}, 32'h0, "host rts full");
    rdm(`DASC_HOST_DATA, 32'hffff_ffff, 32'h45, "host rx");
    hget(8'h11, 100, "host xon");
    chk({31'h0, rts[0]}, 32'h1, "host rts free");
  endtask : t_host
  task automatic t_flow();
    h_far.send(8'h13, 8, 0, 2, 100);
    rdm(`DASC_STATUS, 32'h22, 32'h20, "paused");
    wr(`DASC_HOST_DATA, 32'h22);
    quiet("held by xoff");
    fork
      h_far.send(8'h11, 8, 0, 2, 100);
      hget(8'h22, 100, "resumed");
    join
    cts[0] <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(`DASC_HOST_DATA, 32'h33);
    quiet("held by cts");
    cts[0] <= 1'b1;
    hget(8'h33, 100, "cts resumed");
  endtask : t_flow
  task automatic t_rate();
    int sel_t[3] = '{0, 6, 7};
    int hb_t[3] = '{3200, 50, 50};
    for (int i = 0; i < 3; i++) begin
      host_rate_sel <= sel_t[i][2:0];
      repeat (4) @(posedge pclk);
      wr(`DASC_HOST_DATA, 32'h5a);
      hget(8'h5a, hb_t[i], "host rate");
      // the last stop bit still runs at the old rate; let it drain
      repeat (hb_t[i]) @(posedge pclk);
    end
    host_rate_sel <= 3'h5;
  endtask : t_rate
  task automatic t_prog();
    for (int i = 0; i < 5; i++) begin
      wr(`DASC_CTRL, ctl_t[i]);
      rdm(`DASC_CTRL, 32'hff, ctl_t[i], "ctrl rw");
      wr(`DASC_PROG_DATA, 32'ha7);
      pget(8'h27, i, "prog tx");
      fork
        p_far.send(8'hda, nb_t[i], par_t[i], ns_t[i], bc_t[i]);
        if (ctl_t[i][3]) pget(8'h13, i, "prog xoff");
      join
      rdm(`DASC_STATUS, 32'h0e00, 32'h0200, "prog status");
      rdm(`DASC_PROG_DATA, 32'hffff_ffff, 32'h5a, "prog rx");
      if (ctl_t[i][3]) pget(8'h11, i, "prog xon");
    end
  endtask : t_prog
  // two chars with no read between: newest kept, overrun flagged
  task automatic t_ovr();
    fork
      begin
        p_far.send(8'h61, 8, 0, 2, 100);
        p_far.send(8'h62, 8, 0, 2, 100);
      end
      pget(8'h13, 4, "ovr xoff");
    join
    rdm(`DASC_STATUS, 32'h1200, 32'h1200, "overrun set");
    wr(`DASC_STATUS, 32'h1000);
    rdm(`DASC_STATUS, 32'h1000, 32'h0, "overrun clear");
    rdm(`DASC_PROG_DATA, 32'hff, 32'h62, "overrun newest");
    pget(8'h11, 4, "ovr xon");
  endtask : t_ovr
  // ==========================================================
  // clock, reset and sequence
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    host_rate_sel = 3'h5;
    role = 2'b01;
    cts = 2'b11;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_host();
    t_flow();
    t_rate();
    t_prog();
    t_ovr();
    final_report();
  end
endmodule : dasc_top_tb_top
